// [rtl/pgs_params.svh]
// constants for the port and pin steering block
`ifndef PGS_PARAMS_SVH
`define PGS_PARAMS_SVH

// ----------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------
`define PGS_BASE_A        3'h0
`define PGS_BASE_C        3'h1
`define PGS_OFF_DIR       5'h00
`define PGS_OFF_LEVEL     5'h04
`define PGS_OFF_LATCH     5'h08
`define PGS_OFF_ANALOG    5'h0c
`define PGS_OFF_PULLUP    5'h10
`define PGS_OFF_THRESH    5'h14
`define PGS_OFF_STEER     8'h40

// ----------------------------------------------------------
// reset values
// ----------------------------------------------------------
`define PGS_RST_DIR       6'h3f
`define PGS_RST_LATCH     6'h00
`define PGS_RST_ANALOG    6'h00
`define PGS_RST_PULLUP    6'h00
`define PGS_RST_THRESH    6'h00
`define PGS_RST_STEER     8'h00

// ----------------------------------------------------------
// steering bit positions and masks
// ----------------------------------------------------------
`define PGS_BIT_RX        7
`define PGS_BIT_SDO       6
`define PGS_BIT_SS        5
`define PGS_BIT_T1G       3
`define PGS_BIT_TX        2
`define PGS_BIT_PWMB      1
`define PGS_BIT_CCP       0
`define PGS_STEER_MASK    8'hef
`define PGS_PINS_SMALL    12'h03f
`define PGS_PINS_LARGE    12'hfff

// ----------------------------------------------------------
// pin indices, port a then port c
// ----------------------------------------------------------
`define PGS_RA0           4'h0
`define PGS_RA1           4'h1
`define PGS_RA2           4'h2
`define PGS_RA3           4'h3
`define PGS_RA4           4'h4
`define PGS_RA5           4'h5
`define PGS_RC2           4'h8
`define PGS_RC3           4'h9
`define PGS_RC4           4'ha
`define PGS_RC5           4'hb

`endif

// [rtl/pgs_pkg.sv]
// types for the port and pin steering block
package pgs_pkg;

  // steerable functions, index into the function vectors
  typedef enum logic [2:0] {
    fn_rx   = 3'b000,
    fn_tx   = 3'b001,
    fn_sdo  = 3'b010,
    fn_ss   = 3'b011,
    fn_t1g  = 3'b100,
    fn_pwmb = 3'b101,
    fn_ccp  = 3'b110
  } pgs_fn_type;

  // register kinds behind the address decoder
  typedef enum logic [2:0] {
    reg_dir    = 3'b000,
    reg_level  = 3'b001,
    reg_latch  = 3'b010,
    reg_analog = 3'b011,
    reg_pullup = 3'b100,
    reg_thresh = 3'b101,
    reg_steer  = 3'b110,
    reg_none   = 3'b111
  } pgs_reg_type;

endpackage

// [rtl/pgs_sync.sv]
// two flop synchroniser for the pin inputs
`timescale 1ns/1ps
module pgs_sync (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] async_in,
  output logic      [11:0] sync_out
);
  logic [11:0] stage1;

  // first stage is read only by the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1   <= 12'h000;
      sync_out <= 12'h000;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// [rtl/pgs_steer.sv]
// pin steering matrix for the seven movable functions
`timescale 1ns/1ps
`include "pgs_params.svh"
module pgs_steer (
  input  wire logic        pin14,
  input  wire logic [6:0]  sel,
  input  wire logic [6:0]  func_enable,
  input  wire logic [6:0]  func_out,
  input  wire logic [6:0]  func_drive,
  input  wire logic [11:0] pin_level,
  output logic      [11:0] ovr_active,
  output logic      [11:0] ovr_value,
  output logic      [11:0] ovr_drive,
  output logic      [6:0]  func_in
);
  import pgs_pkg::*;

  // candidate pin for a function, select bit and variant
  function automatic logic [3:0] map_pin(input logic [2:0] fn,
                                         input logic s, input logic w);
    case (fn)
      fn_rx:   map_pin = w ? (s ? `PGS_RA1 : `PGS_RC5) : (s ? `PGS_RA5 : `PGS_RA1);
      fn_sdo:  map_pin = s ? `PGS_RA4 : (w ? `PGS_RC2 : `PGS_RA0);
      fn_ss:   map_pin = w ? (s ? `PGS_RA3 : `PGS_RC3) : (s ? `PGS_RA0 : `PGS_RA3);
      fn_t1g:  map_pin = s ? `PGS_RA3 : `PGS_RA4;
      fn_tx:   map_pin = w ? (s ? `PGS_RA0 : `PGS_RC4) : (s ? `PGS_RA4 : `PGS_RA0);
      fn_pwmb: map_pin = w ? (s ? `PGS_RC2 : `PGS_RC4) : (s ? `PGS_RA4 : `PGS_RA0);
      fn_ccp:  map_pin = w ? (s ? `PGS_RA5 : `PGS_RC5) : (s ? `PGS_RA5 : `PGS_RA2);
      default: map_pin = `PGS_RA0;
    endcase
  endfunction

  // only the selected pin sees the override, the other stays a port pin
  always_comb begin
    logic [3:0] idx;
    idx        = `PGS_RA0;
    ovr_active = 12'h000;
    ovr_value  = 12'h000;
    ovr_drive  = 12'h000;
    func_in    = 7'h00;
    for (int f = 0; f < 7; f++) begin
      idx = map_pin(f[2:0], sel[f], pin14);
      if (func_enable[f]) begin
        ovr_active[idx] = 1'b1;
        ovr_value[idx]  = func_out[f];
        ovr_drive[idx]  = func_drive[f];
      end
      func_in[f] = pin_level[idx];
    end
  end
endmodule

// [rtl/pgs_port.sv]
// apb register file, port latches and pin drivers
//
// The address map and register access over APB were decided locally.
`timescale 1ns/1ps
`include "pgs_params.svh"
module pgs_port #(
  parameter bit PIN14 = 1'b1
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [6:0]  func_enable,
  input  wire logic [6:0]  func_out,
  input  wire logic [6:0]  func_drive,
  output logic      [6:0]  func_in,
  input  wire logic [11:0] pin_in,
  output logic      [11:0] pin_out,
  output logic      [11:0] pin_oe,
  output logic      [11:0] pin_pullup_en,
  output logic      [11:0] pin_input_en,
  output logic      [11:0] pin_threshold_sel
);
  import pgs_pkg::*;

  // ----------------------------------------------------------
  // storage, index 0 is port a and index 1 is port c
  // ----------------------------------------------------------
  // five arrays share one index, so one strobe picks a row
  logic [5:0]  port_direction [0:1];
  logic [5:0]  port_output_latch [0:1];
  logic [5:0]  port_analog_select [0:1];
  logic [5:0]  port_weak_pullup [0:1];
  logic [5:0]  port_input_threshold [0:1];
  logic [7:0]  pin_function_steering;
  logic [11:0] pin_sync;
  logic [11:0] pin_digital;
  logic [11:0] pins_present;
  logic [11:0] dir_flat;
  logic [11:0] latch_flat;
  logic [11:0] analog_flat;
  logic [11:0] pullup_flat;
  logic [11:0] thresh_flat;
  logic [11:0] ovr_active;
  logic [11:0] ovr_value;
  logic [11:0] ovr_drive;
  logic [11:0] next_oe;
  logic [6:0]  steer_sel;
  logic [3:0]  dec;
  logic        dec_port;
  pgs_reg_type dec_kind;
  logic        wr_en;
  logic        wr_dir;
  logic        wr_latch;
  logic        wr_analog;
  logic        wr_pullup;
  logic        wr_thresh;
  logic        wr_steer;
  logic [7:0]  read_mux;
  logic [31:0] next_prdata;
  logic        next_slverr;
  logic [11:0] next_out;
  logic [11:0] pin_owned;

  // ----------------------------------------------------------
  // address decoding
  // ----------------------------------------------------------

  // returns {port, kind}; port c misses on the small variant
  // a miss raises pslverr and reads back zero
  function automatic logic [3:0] decode_addr(input logic [7:0] a,
                                             input logic w);
    pgs_reg_type k;
    logic        p;
    k = reg_none;
    p = 1'b0;
    if (a == `PGS_OFF_STEER) begin
      k = reg_steer;
    end else if (a[7:5] == `PGS_BASE_A || (a[7:5] == `PGS_BASE_C && w)) begin
      p = (a[7:5] == `PGS_BASE_C);
      case (a[4:0])
        `PGS_OFF_DIR:    k = reg_dir;
        `PGS_OFF_LEVEL:  k = reg_level;
        `PGS_OFF_LATCH:  k = reg_latch;
        `PGS_OFF_ANALOG: k = reg_analog;
        `PGS_OFF_PULLUP: k = reg_pullup;
        `PGS_OFF_THRESH: k = reg_thresh;
        default:         k = reg_none;
      endcase
    end
    decode_addr = {p, k};
  endfunction

  // decoder shared by read capture and write strobe
  assign dec      = decode_addr(paddr, PIN14);
  assign dec_port = dec[3];
  assign dec_kind = pgs_reg_type'(dec[2:0]);

  // write lands at the access edge; registers live in byte lane 0
  // other lanes are ignored, a write with lane 0 off does nothing
  assign wr_en = psel && penable && pwrite && pstrb[0] && (dec_kind != reg_none);

  // one strobe per register; the pin-level address lands in the latch too
  assign wr_dir    = wr_en && (dec_kind == reg_dir);
  assign wr_latch  = wr_en && (dec_kind == reg_latch || dec_kind == reg_level);
  assign wr_analog = wr_en && (dec_kind == reg_analog);
  assign wr_pullup = wr_en && (dec_kind == reg_pullup);
  assign wr_thresh = wr_en && (dec_kind == reg_thresh);
  assign wr_steer  = wr_en && (dec_kind == reg_steer);

  // zero wait state slave; nothing here needs more than one edge
  assign pready = 1'b1;

  // ----------------------------------------------------------
  // port registers
  // ----------------------------------------------------------

  // direction, untouched by any steering write
  // resets to all inputs, so no pin drives before software asks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < 2; p++) begin
        port_direction[p] <= `PGS_RST_DIR;
      end
    end else if (wr_dir) begin
      port_direction[dec_port] <= pwdata[5:0];
    end
  end

  // latch is written through either the latch or the pin-level address
  // read-modify-write must use the latch address, the level one sees pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < 2; p++) begin
        port_output_latch[p] <= `PGS_RST_LATCH;
      end
    end else if (wr_latch) begin
      port_output_latch[dec_port] <= pwdata[5:0];
    end
  end

  // analog select
  // a selected pin reads low and never reaches a peripheral input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < 2; p++) begin
        port_analog_select[p] <= `PGS_RST_ANALOG;
      end
    end else if (wr_analog) begin
      port_analog_select[dec_port] <= pwdata[5:0];
    end
  end

  // weak pull-up enables
  // gated later, where the driver state is known
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < 2; p++) begin
        port_weak_pullup[p] <= `PGS_RST_PULLUP;
      end
    end else if (wr_pullup) begin
      port_weak_pullup[dec_port] <= pwdata[5:0];
    end
  end

  // input threshold selects
  // picks the buffer type only, the level logic never sees it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < 2; p++) begin
        port_input_threshold[p] <= `PGS_RST_THRESH;
      end
    end else if (wr_thresh) begin
      port_input_threshold[dec_port] <= pwdata[5:0];
    end
  end

  // steering, the unimplemented bit never stores
  // a change moves the override at the next edge, the old pin falls back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_function_steering <= `PGS_RST_STEER;
    end else if (wr_steer) begin
      pin_function_steering <= pwdata[7:0] & `PGS_STEER_MASK;
    end
  end

  // ----------------------------------------------------------
  // flattened views, port a in the low six bits
  // ----------------------------------------------------------
  assign pins_present = PIN14 ? `PGS_PINS_LARGE : `PGS_PINS_SMALL;

  // port c rows exist on both variants, masked off on the small one
  for (genvar g = 0; g < 2; g++) begin : g_flat
    assign dir_flat[6*g +: 6]    = port_direction[g];
    assign latch_flat[6*g +: 6]  = port_output_latch[g];
    assign analog_flat[6*g +: 6] = port_analog_select[g];
    assign pullup_flat[6*g +: 6] = port_weak_pullup[g];
    assign thresh_flat[6*g +: 6] = port_input_threshold[g];
  end

  // ----------------------------------------------------------
  // pin input path
  // ----------------------------------------------------------

  // pins are asynchronous to pclk
  // two flops, so a pin change reads back two edges late
  pgs_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // analog pins read low, their buffer being off
  assign pin_digital = pin_sync & ~analog_flat & pins_present;

  // ----------------------------------------------------------
  // steering
  // ----------------------------------------------------------

  // logical select per function, in function order
  // bit 4 has no function and never reaches the matrix
  assign steer_sel[fn_rx]   = pin_function_steering[`PGS_BIT_RX];
  assign steer_sel[fn_tx]   = pin_function_steering[`PGS_BIT_TX];
  assign steer_sel[fn_sdo]  = pin_function_steering[`PGS_BIT_SDO];
  assign steer_sel[fn_ss]   = pin_function_steering[`PGS_BIT_SS];
  assign steer_sel[fn_t1g]  = pin_function_steering[`PGS_BIT_T1G];
  assign steer_sel[fn_pwmb] = pin_function_steering[`PGS_BIT_PWMB];
  assign steer_sel[fn_ccp]  = pin_function_steering[`PGS_BIT_CCP];

  // route function overrides and inputs to the selected pins
  // two enabled functions on one pin: the higher index wins
  pgs_steer u_steer (
    .pin14       (PIN14),
    .sel         (steer_sel),
    .func_enable (func_enable),
    .func_out    (func_out),
    .func_drive  (func_drive),
    .pin_level   (pin_digital),
    .ovr_active  (ovr_active),
    .ovr_value   (ovr_value),
    .ovr_drive   (ovr_drive),
    .func_in     (func_in)
  );

  // ----------------------------------------------------------
  // pin output path
  // ----------------------------------------------------------

  // a peripheral owns a pin only where it is steered and the pin exists
  assign pin_owned = ovr_active & pins_present;

  // direction one releases the driver unless a peripheral owns the pin
  assign next_oe  = pin_owned & ovr_drive | ~ovr_active & ~dir_flat & pins_present;

  // unowned pins show the latch, never the sampled level
  assign next_out = pin_owned & ovr_value | ~ovr_active & latch_flat & pins_present;

  // drivers are registered so pins never glitch on decode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 12'h000;
      pin_oe  <= 12'h000;
    end else begin
      pin_out <= next_out;
      pin_oe  <= next_oe;
    end
  end

  // pull-up only while nothing drives the pin, so no fight with the driver
  // buffer enable and threshold share the edge, so a pin changes at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_pullup_en     <= 12'h000;
      pin_input_en      <= 12'h000;
      pin_threshold_sel <= 12'h000;
    end else begin
      pin_pullup_en     <= pullup_flat & ~next_oe & pins_present;
      pin_input_en      <= ~analog_flat & pins_present;
      pin_threshold_sel <= thresh_flat & pins_present;
    end
  end

  // ----------------------------------------------------------
  // read path
  // ----------------------------------------------------------

  // read source by decoded kind
  // unused bits read zero so software can mask freely
  always_comb begin
    read_mux = 8'h00;
    case (dec_kind)
      reg_dir:    read_mux = {2'b00, port_direction[dec_port]};
      reg_level:  read_mux = {2'b00, dec_port ? pin_digital[11:6] : pin_digital[5:0]};
      reg_latch:  read_mux = {2'b00, port_output_latch[dec_port]};
      reg_analog: read_mux = {2'b00, port_analog_select[dec_port]};
      reg_pullup: read_mux = {2'b00, port_weak_pullup[dec_port]};
      reg_thresh: read_mux = {2'b00, port_input_threshold[dec_port]};
      reg_steer:  read_mux = pin_function_steering;
      default:    read_mux = 8'h00;
    endcase
  end

  // answer built in the setup cycle; a write reads back zero
  assign next_prdata = pwrite ? 32'h00000000 : {24'h000000, read_mux};
  assign next_slverr = (dec_kind == reg_none);

  // captured in the setup cycle, presented in the access cycle
  // and held until the next setup, so a slow master still sees it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= next_prdata;
      pslverr <= next_slverr;
    end
  end
endmodule

// [sim/pgs_port_props.sv]
// checker for the port and pin steering block
`timescale 1ns/1ps
module pgs_port_props #(
  parameter bit PIN14 = 1'b1
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [6:0]  func_enable,
  input wire logic [6:0]  func_out,
  input wire logic [6:0]  func_drive,
  input wire logic [11:0] pin_out,
  input wire logic [11:0] pin_oe,
  input wire logic [11:0] pin_pullup_en
);
  logic [5:0] dir_a;
  logic [5:0] latch_a;
  logic [7:0] steer;
  logic       addr_ok;
  logic [7:0] rd_model;
  // decode of mapped words; port c exists only on the wide variant
  assign addr_ok = (paddr == 8'h40) || (paddr[1:0] == 2'h0 && paddr[4:0] <= 5'h14
                   && (paddr[7:5] == 3'h0 || (PIN14 && paddr[7:5] == 3'h1)));
  assign rd_model = (paddr == 8'h00) ? {2'h0, dir_a} :
                    (paddr == 8'h08) ? {2'h0, latch_a} : steer;
  // shadow registers; only writes with byte lane 0 on count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_a <= 6'h3f;
      latch_a <= 6'h00;
      steer <= 8'h00;
    end else if (psel && penable && pwrite && pstrb[0]) begin
      if (paddr == 8'h00) dir_a <= pwdata[5:0];
      if (paddr == 8'h04 || paddr == 8'h08) latch_a <= pwdata[5:0];
      if (paddr == 8'h40) steer <= pwdata[7:0] & 8'hef;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_known_rd;
    psel && !penable && !pwrite && (paddr == 8'h00 || paddr == 8'h08 || paddr == 8'h40);
  endsequence
  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_err_map: assert property (s_setup |=> pslverr == !$past(addr_ok))
    else $error("pslverr wrong for address");
  chk_bad_zero: assert property (s_setup ##0 !addr_ok |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_read_regs: assert property (s_known_rd |=> prdata == {24'h0, $past(rd_model)})
    else $error("register read mismatch");
  chk_pull_driven: assert property ((pin_pullup_en & pin_oe) == 12'h000)
    else $error("pull-up on a driven pin");
  chk_dir_latch: assert property (PIN14 |=>
    pin_oe[2] == !$past(dir_a[2]) && pin_out[2] == $past(latch_a[2]))
    else $error("pin a2 not following port");
  chk_unsel_pin: assert property (PIN14 && !steer[7] |=>
    pin_oe[1] == !$past(dir_a[1]) && pin_out[1] == $past(latch_a[1]))
    else $error("unselected pin disturbed");
  chk_rx_wide: assert property (PIN14 && func_enable[0] && !steer[7]
    && !(func_enable[6] && !steer[0]) |=>
    pin_oe[11] == $past(func_drive[0]) && pin_out[11] == $past(func_out[0]))
    else $error("receive override missing on c5");
  chk_rx_small: assert property (!PIN14 && func_enable[0] && steer[7]
    && !(func_enable[6] && steer[0]) |=>
    pin_oe[5] == $past(func_drive[0]) && pin_out[5] == $past(func_out[0]))
    else $error("receive override missing on a5");
endmodule
bind pgs_port pgs_port_props #(.PIN14(PIN14)) i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .func_enable(func_enable), .func_out(func_out),
  .func_drive(func_drive), .pin_out(pin_out), .pin_oe(pin_oe),
  .pin_pullup_en(pin_pullup_en));

// [sim/pgs_pins.sv]
// model of the circuitry on the device pins
`timescale 1ns/1ps
module pgs_pins (
  input  wire logic        pclk,
  input  wire logic [11:0] pin_out,
  input  wire logic [11:0] pin_oe,
  input  wire logic [11:0] pin_pullup_en,
  input  wire logic [11:0] ext_en,
  input  wire logic [11:0] ext_val,
  output logic      [11:0] pin_in
);
  logic [11:0] float_pat = 12'h000;
  // a floating pin wanders, so nothing may lean on its last value
  always @(posedge pclk) float_pat <= ~float_pat;
  // device drive wins, then the outside source, then the weak pull-up
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_val[i];
      else if (pin_pullup_en[i])
        pin_in[i] = 1'b1;
      else
        pin_in[i] = float_pat[i];
    end
  end
endmodule

// [sim/pgs_port_bench.sv]
// self-checking bench for the port and pin steering block
`timescale 1ns/1ps
module pgs_port_bench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [6:0]  func_enable = 7'h00;
  logic [6:0]  func_out = 7'h00;
  logic [6:0]  func_drive = 7'h00;
  logic [6:0]  func_in;
  logic [11:0] pin_in, pin_out, pin_oe, pin_pullup_en, pin_input_en, pin_threshold_sel;
  logic [11:0] ext_en = 12'h000;
  logic [11:0] ext_val = 12'h000;
  logic [11:0] pin_out8, pin_oe8;
  int          failures = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  always #25 pclk = ~pclk;
  // the wide variant is the main target; the small one shares bus and pins
  pgs_port #(.PIN14(1'b1)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .func_enable(func_enable),
    .func_out(func_out), .func_drive(func_drive), .func_in(func_in), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
    .pin_input_en(pin_input_en), .pin_threshold_sel(pin_threshold_sel));
  pgs_port #(.PIN14(1'b0)) i_dut8 (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(), .pready(), .pslverr(), .func_enable(func_enable), .func_out(func_out),
    .func_drive(func_drive), .func_in(), .pin_in(pin_in), .pin_out(pin_out8),
    .pin_oe(pin_oe8), .pin_pullup_en(), .pin_input_en(), .pin_threshold_sel());
  pgs_pins i_pins (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  task automatic end_of_test();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // hang guard, far above the roughly 140 cycles the tests need
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one bus transfer; held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] exp, input logic err);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    cmp(r, exp);
    cmp({31'h0, e}, {31'h0, err});
  endtask
  // outputs are sampled on the falling edge, where they have settled
  task automatic tick(input int n);
    repeat (n) @(negedge pclk);
  endtask
  task automatic setf(input logic [6:0] en, input logic [6:0] drv, input logic [6:0] val);
    @(posedge pclk);
    func_enable <= en;
    func_drive <= drv;
    func_out <= val;
  endtask
  task automatic setx(input logic [11:0] en, input logic [11:0] val);
    @(posedge pclk);
    ext_en <= en;
    ext_val <= val;
  endtask
  task automatic t_reset();
    logic [7:0] adr [9] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20, 8'h40, 8'h18, 8'h44};
    logic [7:0] exp [9] = '{8'h3f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3f, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 9; i++) chk(adr[i], {24'h0, exp[i]}, i > 6);
    cmp({20'h0, pin_oe8}, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_latch();
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h2a);
    chk(8'h08, 32'h2a, 1'b0);
    tick(4);
    cmp({20'h0, pin_oe}, 32'h3f);
    cmp({20'h0, pin_out}, 32'h2a);
    chk(8'h04, 32'h2a, 1'b0);
    wr(8'h00, 32'h3f);
    setx(12'h03f, 12'h015);
    tick(4);
    cmp({20'h0, pin_oe}, 32'h0);
    chk(8'h04, 32'h15, 1'b0);
    chk(8'h08, 32'h2a, 1'b0);
    $display("test latch done");
  endtask
  task automatic t_analog();
    wr(8'h0c, 32'h01);
    tick(4);
    chk(8'h04, 32'h14, 1'b0);
    cmp({31'h0, pin_input_en[0]}, 32'h0);
    wr(8'h10, 32'h3f);
    wr(8'h14, 32'h2d);
    wr(8'h0c, 32'h00);
    tick(2);
    cmp({20'h0, pin_pullup_en}, 32'h3f);
    cmp({20'h0, pin_threshold_sel}, 32'h2d);
    cmp({20'h0, pin_input_en}, 32'hfff);
    $display("test analog done");
  endtask
  task automatic t_steer();
    wr(8'h00, 32'h2a);
    wr(8'h40, 32'hff);
    chk(8'h40, 32'hef, 1'b0);
    @(posedge pclk);
    pstrb <= 4'he;
    wr(8'h40, 32'h00);
    pstrb <= 4'hf;
    chk(8'h40, 32'hef, 1'b0);
    chk(8'h00, 32'h2a, 1'b0);
    wr(8'h00, 32'h3f);
    wr(8'h40, 32'h00);
    setf(7'h01, 7'h01, 7'h01);
    tick(2);
    cmp({30'h0, pin_oe[11], pin_oe[1]}, 32'h2);
    cmp({30'h0, pin_out[11], pin_oe8[1]}, 32'h3);
    wr(8'h40, 32'h80);
    tick(2);
    cmp({30'h0, pin_oe[11], pin_oe[1]}, 32'h1);
    cmp({30'h0, pin_oe8[5], pin_oe8[1]}, 32'h2);
    setf(7'h04, 7'h04, 7'h04);
    wr(8'h40, 32'h00);
    tick(2);
    cmp({30'h0, pin_oe[8], pin_oe8[0]}, 32'h3);
    wr(8'h40, 32'h40);
    tick(2);
    cmp({29'h0, pin_oe[4], pin_oe8[4], pin_oe[8]}, 32'h6);
    $display("test steer done");
  endtask
  task automatic t_func_in();
    setf(7'h01, 7'h00, 7'h00);
    wr(8'h40, 32'h00);
    setx(12'h800, 12'h800);
    tick(4);
    cmp({31'h0, func_in[0]}, 32'h1);
    setx(12'h800, 12'h000);
    tick(4);
    cmp({31'h0, func_in[0]}, 32'h0);
    $display("test func_in done");
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_latch();
    t_analog();
    t_steer();
    t_func_in();
    end_of_test();
  end
endmodule
